// File: bench/bsfc_flash_model.sv
// Purpose: Behavioural flash device on the far side of the host controller
// Assumes: Word addresses in word mode, byte addresses in byte mode
// Notes: Boot sectors folded into uniform sectors; no program during suspend
`timescale 1ns/1ns
module bsfc_flash_model #(
   parameter int PROG_NS = 400,
   parameter int ERASE_NS = 2000,
   parameter logic [31:0] PROT_SECT = 32'h00000020
) (
   input wire logic [20:0] addr_in,             // Address pins
   input wire logic [15:0] dq_in,               // Resolved data bus
   input wire logic chip_select_low_in,         // Chip select
   input wire logic write_strobe_low_in,        // Write strobe
   input wire logic read_output_enable_low_in,  // Output enable
   input wire logic hard_restart_low_in,        // Hard restart
   input wire logic byte_mode_low_in,           // Low = byte mode
   input wire logic low_supply_in,              // Supply in transition
   input wire logic slow_in,                    // Stretch busy times
   output logic [15:0] dq_out,                  // Data drive
   output logic ready_busy_n_out                // High when ready
);
   logic [15:0] mem [logic [20:0]];
   logic [20:0] ks [$];
   logic [15:0] op_d, rd_val, last_val;
   logic [20:0] op_a;
   logic [7:0] d;
   logic in_wr, bypass, busy, susp, erasing, tog;
   int step, left_ns, n_wr;
   time addr_t;

   function automatic logic [4:0] sect(input logic [20:0] a);
      return byte_mode_low_in ? a[19:15] : a[20:16];
   endfunction
   function automatic logic [20:0] ua(input logic [20:0] w);
      return byte_mode_low_in ? w : {w[19:0], 1'b0};
   endfunction
   task automatic start(input int ns, input logic er);
      busy = 1'b1;
      erasing = er;
      left_ns = slow_in ? 4 * ns : ns;
   endtask

   initial begin
      {in_wr, bypass, busy, susp, erasing, tog} = '0;
      {last_val, rd_val, op_d, op_a, addr_t} = '0;
   end
   assign ready_busy_n_out = !busy || susp;

   // ************
   // Command writes, latched when the strobe or select rises
   // ************
   always @(chip_select_low_in or write_strobe_low_in) begin
      if (!chip_select_low_in && !write_strobe_low_in) begin
         in_wr = 1'b1;
      end else if (in_wr) begin
         in_wr = 1'b0;
         d = dq_in[7:0];
         if (hard_restart_low_in && !low_supply_in) begin
            n_wr++;
            if (busy) begin
               if (erasing && !susp && d == 8'hb0) susp = 1'b1;
               else if (susp && d == 8'h30) susp = 1'b0;
            end else if (d == 8'hf0) step = 0;
            else case (step)
               0: if (bypass && d == 8'ha0) step = 3;
                  else if (bypass && d == 8'h90) step = 6;
                  else if (addr_in == ua(21'h000555) && d == 8'haa) step = 1;
               1: step = (addr_in == ua(21'h0002aa) && d == 8'h55) ? 2 : 0;
               2: begin
                  step = d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
                  if (d == 8'h20) bypass = 1'b1;
               end
               3: begin
                  step = 0;
                  op_a = addr_in;
                  op_d = byte_mode_low_in ? dq_in : {8'h00, d};
                  if (!PROT_SECT[sect(addr_in)]) start(PROG_NS, 1'b0);
               end
               4: step = d == 8'haa ? 5 : 0;
               5: step = d == 8'h55 ? 7 : 0;
               7: begin
                  step = 0;
                  op_a = addr_in;
                  op_d = 16'hffff;
                  if (d == 8'h30 && !PROT_SECT[sect(addr_in)]) start(ERASE_NS, 1'b1);
               end
               default: begin
                  if (d == 8'h00) bypass = 1'b0;
                  step = 0;
               end
            endcase
         end
      end
   end

   // ************
   // Algorithm timer, abort and reads
   // ************
   always #20 begin
      if (busy && !susp) begin
         left_ns -= 20;
         if (left_ns <= 0) begin
            if (erasing) begin
               foreach (mem[k]) if (sect(k) == sect(op_a)) ks.push_back(k);
               foreach (ks[i]) mem.delete(ks[i]);
               ks.delete();
            end else mem[op_a] = op_d;
            busy = 1'b0;
         end
      end
   end
   always @(addr_in) addr_t = $time; // Sleep timer restarts
   always @(negedge hard_restart_low_in) begin
      {busy, susp, bypass, erasing} = '0;
      step = 0;
   end
   always @(negedge read_output_enable_low_in) begin
      if (busy) tog = ~tog;
      #1;
      if (busy && !(susp && sect(addr_in) != sect(op_a))) rd_val = {8'h00, ~op_d[7], tog, 6'h00};
      else rd_val = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
      if (!byte_mode_low_in) rd_val[15:8] = 8'h00;
   end
   always @(posedge read_output_enable_low_in) last_val = rd_val;
   // Released bus shows the inverse so a stale value never passes
   assign dq_out = (!chip_select_low_in && !read_output_enable_low_in) ? rd_val : ~last_val;
endmodule

// File: bench/bsfc_host_bench.sv
// Purpose: Self-checking bench for the boot sector flash host controller
// Assumes: Flash model on the far side
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ns
module bsfc_host_bench;
   import bsfc_pkg::*;
   logic clk_sys_in, rst_in, req_valid_in, byte_mode_in, low_supply, slow;
   bsfc_req_s req_in;
   logic req_ready_out, done_out, bypass_out, suspended_out, dq_oe_out, ready_busy_n;
   logic chip_select_low_out, write_strobe_low_out, read_output_enable_low_out;
   logic hard_restart_low_out, byte_mode_low_out;
   logic [15:0] rdata_out, dq_out, dev_dq, dq_bus;
   logic [20:0] addr_out;
   int n_errors, n_compared, cyc, n_rst_low, w;

   assign dq_bus = dq_oe_out ? dq_out : dev_dq;
   bsfc_host dut (.*, .ready_busy_n_in(ready_busy_n), .dq_in(dq_bus));
   bsfc_flash_model dev (.addr_in(addr_out), .dq_in(dq_bus),
      .chip_select_low_in(chip_select_low_out), .write_strobe_low_in(write_strobe_low_out),
      .read_output_enable_low_in(read_output_enable_low_out),
      .hard_restart_low_in(hard_restart_low_out), .byte_mode_low_in(byte_mode_low_out),
      .low_supply_in(low_supply), .slow_in(slow), .dq_out(dev_dq),
      .ready_busy_n_out(ready_busy_n));

   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   always @(negedge clk_sys_in) begin
      cyc++;
      if (hard_restart_low_out === 1'b0) n_rst_low++;
      if (cyc == 50000) begin
         n_errors++;
         end_sim;
      end
   end

   // ************
   // Shared tasks
   // ************
   task automatic end_sim;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic do_req(input bsfc_op_e op, input logic [20:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (req_ready_out !== 1'b1 && n < 100) begin
         @(negedge clk_sys_in);
         n++;
      end
      req_in = '{op: op, addr: a, data: d};
      req_valid_in = 1'b1;
      @(negedge clk_sys_in);
      req_valid_in = 1'b0;
      n = 0;
      while (done_out !== 1'b1 && n < 2000) begin
         @(negedge clk_sys_in);
         n++;
      end
      chk(21'(done_out), 21'd1);
   endtask
   task automatic rd(input logic [20:0] a, input logic [15:0] e);
      do_req(BSFC_OP_READ, a, 16'h0000);
      chk(21'(rdata_out), 21'(e));
   endtask
   task automatic prog_n(input logic [20:0] a, input logic [15:0] d, input int n);
      w = dev.n_wr;
      do_req(BSFC_OP_PROG, a, d);
      chk(21'(dev.n_wr - w), 21'(n));
   endtask

   // ************
   // Scenarios
   // ************
   task automatic t_prog;
      prog_n(21'h000123, 16'h5a3c, 4);
      chk(21'(rdata_out), 21'h005a3c);
      rd(21'h000123, 16'h5a3c);
      rd(21'h000124, 16'hffff);
   endtask
   task automatic t_bypass;
      do_req(BSFC_OP_BYP_ENTER, 21'h0, 16'h0);
      chk(21'(bypass_out), 21'd1);
      prog_n(21'h000200, 16'h1111, 2);
      prog_n(21'h000201, 16'h2222, 2);
      rd(21'h000201, 16'h2222);
      do_req(BSFC_OP_BYP_EXIT, 21'h0, 16'h0);
      chk(21'(bypass_out), 21'd0);
   endtask
   task automatic t_erase;
      slow = 1'b1;
      prog_n(21'h008010, 16'habcd, 4);
      prog_n(21'h010020, 16'h1234, 4);
      do_req(BSFC_OP_SECT_ERASE, 21'h008000, 16'h0);
      slow = 1'b0;
      rd(21'h008010, 16'hffff);
      rd(21'h010020, 16'h1234);
      prog_n(21'h028004, 16'h0f0f, 4); // Protected sector
      rd(21'h028004, 16'hffff);
      low_supply = 1'b1;
      prog_n(21'h000300, 16'h7777, 0);
      low_supply = 1'b0;
      rd(21'h000300, 16'hffff);
   endtask
   task automatic t_modes;
      do_req(BSFC_OP_SUSPEND, 21'h0, 16'h0);
      chk(21'(suspended_out), 21'd1);
      do_req(BSFC_OP_RESUME, 21'h0, 16'h0);
      chk(21'(suspended_out), 21'd0);
      do_req(BSFC_OP_BYP_ENTER, 21'h0, 16'h0);
      n_rst_low = 0;
      do_req(BSFC_OP_HARD_RESET, 21'h0, 16'h0);
      chk(21'(n_rst_low), 21'd13);
      chk(21'(bypass_out), 21'd0);
      prog_n(21'h000400, 16'h0400, 4);
      rd(21'h000400, 16'h0400);
      do_req(BSFC_OP_STANDBY, 21'h0, 16'h0);
      chk(21'(chip_select_low_out), 21'd1);
      do_req(BSFC_OP_RESET_CMD, 21'h0, 16'h0);
      rd(21'h000123, 16'h5a3c);
      byte_mode_in = 1'b1;
      prog_n(21'h000801, 16'hbbc3, 4);
      chk(21'(byte_mode_low_out), 21'd0);
      rd(21'h000801, 16'h00c3);
      rd(21'h000800, 16'h00ff);
      byte_mode_in = 1'b0;
   endtask

   initial begin
      {rst_in, req_valid_in, byte_mode_in, low_supply, slow} = 5'b10000;
      req_in = '0;
      repeat (10) @(negedge clk_sys_in);
      chk(21'({chip_select_low_out, write_strobe_low_out, read_output_enable_low_out}), 21'd7);
      chk(21'({hard_restart_low_out, byte_mode_low_out, dq_oe_out, req_ready_out}), 21'hc);
      rst_in = 1'b0;
      t_prog;
      t_bypass;
      t_erase;
      t_modes;
      end_sim;
   end
endmodule

// File: src/bsfc_bus_cycle.sv
// Purpose: One timed write or read cycle on the flash strobes
// Assumes: Strobes are active low, data pins are two-way
// Notes: Reads sample the data bus once access time has passed
`timescale 1ns/1ns
`include "bsfc_params.svh"
module bsfc_bus_cycle (
   input wire logic clk_sys_in,                 // System clock
   input wire logic rst_in,                     // Sync reset, active high
   input wire logic start_in,                   // Start a cycle, pulse
   input wire logic write_in,                   // 1 write, 0 read
   input wire bsfc_pkg::bsfc_cycle_s cyc_in,    // Address and data
   input wire logic [15:0] dq_sync_in,          // Synchronised data pins
   output logic done_out,                       // Cycle complete, pulse
   output logic [15:0] rdata_out,               // Sampled read data
   output logic [20:0] addr_out,                // Address pins
   output logic [15:0] dq_out,                  // Data pin drive
   output logic dq_oe_out,                      // Data pin enable
   output logic chip_select_low_out,            // Chip select, active low
   output logic write_strobe_low_out,           // Write strobe, active low
   output logic read_output_enable_low_out      // Output enable, active low
);
   import bsfc_pkg::*;

   typedef enum logic [1:0] {BSFC_C_IDLE, BSFC_C_LOW, BSFC_C_HIGH} bsfc_cst_e;
   bsfc_cst_e state;
   logic [3:0] cnt;
   logic is_write;
   // Two extra cycles cover the synchroniser delay on read data
   localparam logic [3:0] RD_CYC = 4'(`BSFC_RD_ACC_CYC + 2);

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state <= BSFC_C_IDLE;
         cnt <= 4'h0;
         is_write <= 1'b0;
         done_out <= 1'b0;
         rdata_out <= 16'h0000;
         addr_out <= 21'h000000;
         dq_out <= 16'h0000;
         dq_oe_out <= 1'b0;
         chip_select_low_out <= 1'b1;
         write_strobe_low_out <= 1'b1;
         read_output_enable_low_out <= 1'b1;
      end else begin
         done_out <= 1'b0;
         unique case (state)
            BSFC_C_IDLE: if (start_in) begin
               // Only one of write strobe and output enable low at a time avoids contention, see R18
               is_write <= write_in;
               addr_out <= cyc_in.addr;
               dq_out <= cyc_in.data;
               dq_oe_out <= write_in;
               chip_select_low_out <= 1'b0;
               write_strobe_low_out <= !write_in;
               read_output_enable_low_out <= write_in;
               cnt <= write_in ? 4'(`BSFC_WR_LOW_CYC) : RD_CYC;
               state <= BSFC_C_LOW;
            end
            BSFC_C_LOW: begin
               if (cnt > 4'h1) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  if (!is_write) begin
                     rdata_out <= dq_sync_in;
                  end
                  chip_select_low_out <= 1'b1;
                  write_strobe_low_out <= 1'b1;
                  read_output_enable_low_out <= 1'b1;
                  cnt <= 4'(`BSFC_WR_HIGH_CYC);
                  state <= BSFC_C_HIGH;
               end
            end
            BSFC_C_HIGH: begin
               if (cnt > 4'h1) begin
                  cnt <= cnt - 4'h1;
               end else begin
                  dq_oe_out <= 1'b0;
                  done_out <= 1'b1;
                  state <= BSFC_C_IDLE;
               end
            end
         endcase
      end
   end

   property p_no_contend;
      @(posedge clk_sys_in) disable iff (rst_in)
         !(dq_oe_out && !read_output_enable_low_out);
   endproperty
   a_no_contend: assert property (p_no_contend) // see R18
      else $error("Data driven while device output enabled");

   property p_write_pulse;
      @(posedge clk_sys_in) disable iff (rst_in)
         $fell(write_strobe_low_out) |-> !chip_select_low_out && dq_oe_out
            && read_output_enable_low_out;
   endproperty
   a_write_pulse: assert property (p_write_pulse) // see R1
      else $error("Write strobe without chip select or data");
endmodule

// File: src/bsfc_host.sv
// Purpose: Host controller driving a boot sector parallel flash by its pins
// Assumes: Device pins are asynchronous to clk_sys_in
// Notes: One request at a time
//
// What the datasheet requires
// R1: Commands go out as plain write cycles to the command register.
// R2: Each write cycle presents address and data for the device to latch.
// R3: Program sequence end starts the automatic program algorithm.
// R4: Bypass mode programs in two writes; otherwise four writes.
// R5: Erase sequence end starts the automatic erase algorithm.
// R6: Completion seen on ready_busy_n pin or by poll and toggle bits; code waits for the pin high, then polls the toggle bit only.
// R7: After completion the device reads array and takes new commands.
// R8: Sector erase changes only the chosen sector.
// R9: Device ignores writes during low supply transitions.
// R10: Device refuses program and erase of protected sectors.
// R11: Erase may be suspended indefinitely, then resumed; code sends suspend only after an erase request has finished.
// R12: Hard restart pin aborts operations and returns to array read.
// R13: Device sleeps after addresses stay unchanged for a while.
// R14: Host may place device in standby.
// R15: Word mode uses sixteen data lines, byte mode the low eight.
// R16: Array addressed as bytes or words by bus width.
// R17: Array split into sectors of 16, 8, 32 and 64 Kbyte.
// R18: Host drives separate chip select, write and output strobes.
// R19: During an algorithm reads of the region return status.
`timescale 1ns/1ns
`include "bsfc_params.svh"
module bsfc_host (
   input wire logic clk_sys_in,                 // System clock, 25 MHz
   input wire logic rst_in,                     // Sync reset, active high
   input wire bsfc_pkg::bsfc_req_s req_in,      // Request
   input wire logic req_valid_in,               // Request valid
   input wire logic byte_mode_in,               // 1 selects byte-wide bus
   output logic req_ready_out,                  // Ready for a request
   output logic done_out,                       // Request finished, pulse
   output logic [15:0] rdata_out,               // Read data
   output logic bypass_out,                     // Bypass mode active
   output logic suspended_out,                  // Erase suspended
   input wire logic ready_busy_n_in,            // Device ready pin
   input wire logic [15:0] dq_in,               // Data pins in
   output logic [15:0] dq_out,                  // Data pins out
   output logic dq_oe_out,                      // Data pins enable
   output logic [20:0] addr_out,                // Address pins
   output logic chip_select_low_out,            // Chip select, active low
   output logic write_strobe_low_out,           // Write strobe, active low
   output logic read_output_enable_low_out,     // Output enable, active low
   output logic hard_restart_low_out,           // Hard restart pin, active low
   output logic byte_mode_low_out               // Bus width select, low = byte
);
   import bsfc_pkg::*;

   //****************************************
   // Pin synchronisers
   //****************************************
   logic [16:0] pin_meta;
   logic [16:0] pin_sync;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pin_meta <= 17'h00000;
         pin_sync <= 17'h00000;
      end else begin
         pin_meta <= {ready_busy_n_in, dq_in};
         pin_sync <= pin_meta;
      end
   end

   //****************************************
   // Sequencer
   //****************************************
   typedef enum logic [2:0] {
      BSFC_IDLE, BSFC_ISSUE, BSFC_WAIT, BSFC_POLL_A, BSFC_POLL_B, BSFC_RST, BSFC_FINISH
   } bsfc_st_e;
   bsfc_st_e state;
   bsfc_req_s cur;
   logic [2:0] step;
   logic [2:0] nsteps;
   logic cyc_start;
   logic cyc_write;
   logic cyc_done;
   bsfc_cycle_s cyc;
   logic [15:0] cyc_rdata;
   logic [15:0] poll_prev;
   logic [7:0] rst_cnt;
   logic wait_alg;

   // Byte mode doubles unlock addresses, see R16
   function automatic logic [20:0] unlock_addr(input logic [20:0] a, input logic bm);
      unlock_addr = bm ? {a[19:0], 1'b0} : a;
   endfunction

   function automatic logic [2:0] step_count(input bsfc_op_e op, input logic byp);
      unique case (op)
         BSFC_OP_PROG: step_count = byp ? 3'd2 : 3'd4; // see R4
         BSFC_OP_SECT_ERASE: step_count = 3'd6;
         BSFC_OP_BYP_ENTER: step_count = 3'd3;
         BSFC_OP_BYP_EXIT: step_count = 3'd2;
         BSFC_OP_READ: step_count = 3'd1;
         default: step_count = 3'd1;
      endcase
   endfunction

   // Current write of the command sequence, see R1
   always_comb begin
      cyc.addr = unlock_addr(`BSFC_UNLOCK_A1, byte_mode_in);
      cyc.data = `BSFC_UNLOCK_D1;
      cyc_write = 1'b1;
      if (cur.op == BSFC_OP_READ) begin
         cyc.addr = cur.addr;
         cyc_write = 1'b0;
      end else if (step == nsteps - 3'd1) begin
         // Final write carries the target address and data or command; bypass entry goes to the first unlock address, see R2
         cyc.addr = cur.addr;
         unique case (cur.op)
            BSFC_OP_PROG: cyc.data = byte_mode_in ? {8'h00, cur.data[7:0]} : cur.data; // see R15
            BSFC_OP_SECT_ERASE: cyc.data = `BSFC_CMD_SECT; // see R8
            BSFC_OP_BYP_ENTER: begin
               cyc.addr = unlock_addr(`BSFC_UNLOCK_A1, byte_mode_in);
               cyc.data = `BSFC_CMD_BYP;
            end
            BSFC_OP_BYP_EXIT: cyc.data = `BSFC_CMD_BYP_X2;
            BSFC_OP_SUSPEND: cyc.data = `BSFC_CMD_SUSP; // see R11
            BSFC_OP_RESUME: cyc.data = `BSFC_CMD_RESUME;
            default: cyc.data = `BSFC_CMD_RESET;
         endcase
      end else if (cur.op == BSFC_OP_PROG && bypass_out) begin
         cyc.data = `BSFC_CMD_PROG;
      end else if (cur.op == BSFC_OP_BYP_EXIT) begin
         cyc.addr = cur.addr;
         cyc.data = `BSFC_CMD_BYP_X1;
      end else if (step == 3'd1 || step == 3'd4) begin
         cyc.addr = unlock_addr(`BSFC_UNLOCK_A2, byte_mode_in);
         cyc.data = `BSFC_UNLOCK_D2;
      end else if (step == 3'd2) begin
         cyc.data = (cur.op == BSFC_OP_PROG) ? `BSFC_CMD_PROG : `BSFC_CMD_ERASE;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state <= BSFC_IDLE;
         cur <= '0;
         step <= 3'd0;
         nsteps <= 3'd1;
         cyc_start <= 1'b0;
         wait_alg <= 1'b0;
         poll_prev <= 16'h0000;
         rst_cnt <= 8'h00;
         req_ready_out <= 1'b0;
         done_out <= 1'b0;
         rdata_out <= 16'h0000;
         bypass_out <= 1'b0;
         suspended_out <= 1'b0;
         hard_restart_low_out <= 1'b1;
      end else begin
         cyc_start <= 1'b0;
         done_out <= 1'b0;
         unique case (state)
            BSFC_IDLE: begin
               req_ready_out <= 1'b1;
               if (req_valid_in && req_ready_out) begin
                  req_ready_out <= 1'b0;
                  cur <= req_in;
                  step <= 3'd0;
                  nsteps <= step_count(req_in.op, bypass_out);
                  wait_alg <= req_in.op == BSFC_OP_PROG || req_in.op == BSFC_OP_SECT_ERASE;
                  if (req_in.op == BSFC_OP_HARD_RESET) begin
                     hard_restart_low_out <= 1'b0; // see R12
                     rst_cnt <= 8'(`BSFC_RST_LOW_CYC);
                     state <= BSFC_RST;
                  end else if (req_in.op == BSFC_OP_STANDBY) begin
                     state <= BSFC_FINISH; // Chip select stays high: standby, see R14
                  end else begin
                     cyc_start <= 1'b1;
                     state <= BSFC_ISSUE;
                  end
               end
            end
            BSFC_ISSUE: if (cyc_done) begin
               if (step == nsteps - 3'd1) begin
                  rdata_out <= cyc_rdata;
                  // Algorithm runs in device, see R3 R5; give busy pin time to fall
                  rst_cnt <= 8'(`BSFC_BUSY_SETTLE_CYC);
                  state <= wait_alg ? BSFC_WAIT : BSFC_FINISH;
               end else begin
                  step <= step + 3'd1;
                  cyc_start <= 1'b1;
               end
            end
            BSFC_WAIT: begin
               // Polling starts only once the ready pin reads high, then confirms the end by the toggle bit
               if (rst_cnt != 8'h00) begin
                  rst_cnt <= rst_cnt - 8'h01;
               end else if (pin_sync[16]) begin
                  step <= 3'd0;
                  nsteps <= 3'd1;
                  cur.op <= BSFC_OP_READ;
                  cyc_start <= 1'b1;
                  state <= BSFC_POLL_A;
               end
            end
            BSFC_POLL_A: if (cyc_done) begin
               poll_prev <= cyc_rdata;
               cyc_start <= 1'b1;
               state <= BSFC_POLL_B;
            end
            BSFC_POLL_B: if (cyc_done) begin
               // Toggle bit steady means the algorithm ended, see R6 R19
               if (cyc_rdata[`BSFC_TOGGLE_BIT] == poll_prev[`BSFC_TOGGLE_BIT]) begin
                  rdata_out <= cyc_rdata;
                  state <= BSFC_FINISH; // Device back in array read, see R7
               end else begin
                  poll_prev <= cyc_rdata;
                  cyc_start <= 1'b1;
               end
            end
            BSFC_RST: begin
               if (rst_cnt > 8'h01) begin
                  rst_cnt <= rst_cnt - 8'h01;
               end else begin
                  hard_restart_low_out <= 1'b1;
                  bypass_out <= 1'b0;
                  suspended_out <= 1'b0;
                  state <= BSFC_FINISH;
               end
            end
            BSFC_FINISH: begin
               done_out <= 1'b1;
               unique case (cur.op)
                  BSFC_OP_BYP_ENTER: bypass_out <= 1'b1;
                  BSFC_OP_BYP_EXIT: bypass_out <= 1'b0;
                  BSFC_OP_RESET_CMD: bypass_out <= 1'b0;
                  BSFC_OP_SUSPEND: suspended_out <= 1'b1;
                  BSFC_OP_RESUME: suspended_out <= 1'b0;
                  default: ;
               endcase
               state <= BSFC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         byte_mode_low_out <= 1'b1;
      end else begin
         byte_mode_low_out <= !byte_mode_in; // see R15
      end
   end

   bsfc_bus_cycle u_cycle (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .start_in(cyc_start),
      .write_in(cyc_write),
      .cyc_in(cyc),
      .dq_sync_in(pin_sync[15:0]),
      .done_out(cyc_done),
      .rdata_out(cyc_rdata),
      .addr_out(addr_out),
      .dq_out(dq_out),
      .dq_oe_out(dq_oe_out),
      .chip_select_low_out(chip_select_low_out),
      .write_strobe_low_out(write_strobe_low_out),
      .read_output_enable_low_out(read_output_enable_low_out)
   );

   //****************************************
   // Checks
   //****************************************
   property p_byp_two;
      @(posedge clk_sys_in) disable iff (rst_in)
         (state == BSFC_IDLE && req_valid_in && req_ready_out && req_in.op == BSFC_OP_PROG)
         |=> (nsteps == (bypass_out ? 3'd2 : 3'd4));
   endproperty
   a_byp_two: assert property (p_byp_two) // see R4
      else $error("Program write count wrong");

   property p_restart_width;
      @(posedge clk_sys_in) disable iff (rst_in)
         $fell(hard_restart_low_out) |-> !hard_restart_low_out [*8];
   endproperty
   a_restart_width: assert property (p_restart_width) // see R12
      else $error("Hard restart pulse too short");

   property p_wait_busy;
      @(posedge clk_sys_in) disable iff (rst_in)
         (state == BSFC_WAIT && rst_cnt == 8'h00 && !pin_sync[16]) |=> state == BSFC_WAIT;
   endproperty
   a_wait_busy: assert property (p_wait_busy) // see R6
      else $error("Left wait while device busy");

   property p_done_idle;
      @(posedge clk_sys_in) disable iff (rst_in)
         done_out |-> state == BSFC_IDLE ##1 req_ready_out;
   endproperty
   a_done_idle: assert property (p_done_idle) // see R7
      else $error("Not ready after completion");

   property p_alg_wait;
      @(posedge clk_sys_in) disable iff (rst_in)
         (state == BSFC_ISSUE && cyc_done && step == nsteps - 3'd1 && wait_alg)
         |=> state == BSFC_WAIT;
   endproperty
   a_alg_wait: assert property (p_alg_wait) // see R3
      else $error("Algorithm not awaited");

   property p_standby_idle;
      @(posedge clk_sys_in) disable iff (rst_in)
         (state == BSFC_IDLE) |-> chip_select_low_out;
   endproperty
   a_standby_idle: assert property (p_standby_idle) // see R14
      else $error("Chip selected while idle");
endmodule

// File: src/bsfc_params.svh
// Purpose: Constants for the boot sector flash host controller
// Assumes: 25 MHz system clock, 40 ns period
// Notes: Command codes follow the common single-supply flash command set
`ifndef BSFC_PARAMS_SVH
`define BSFC_PARAMS_SVH

`define BSFC_CLK_NS 40
// Least times in ns, rounded up to whole cycles
`define BSFC_CYC(ns) (((ns) + `BSFC_CLK_NS - 1) / `BSFC_CLK_NS)
`define BSFC_WR_LOW_NS 35
`define BSFC_WR_HIGH_NS 30
`define BSFC_RD_ACC_NS 90
`define BSFC_WR_LOW_CYC `BSFC_CYC(`BSFC_WR_LOW_NS)
`define BSFC_WR_HIGH_CYC `BSFC_CYC(`BSFC_WR_HIGH_NS)
`define BSFC_RD_ACC_CYC `BSFC_CYC(`BSFC_RD_ACC_NS)
// Hardware reset pulse width in ns
`define BSFC_RST_LOW_NS 500
`define BSFC_RST_LOW_CYC `BSFC_CYC(`BSFC_RST_LOW_NS)
`define BSFC_BUSY_SETTLE_CYC 8

`define BSFC_UNLOCK_A1 21'h000555
`define BSFC_UNLOCK_A2 21'h0002aa
`define BSFC_UNLOCK_D1 16'h00aa
`define BSFC_UNLOCK_D2 16'h0055
`define BSFC_CMD_PROG 16'h00a0
`define BSFC_CMD_ERASE 16'h0080
`define BSFC_CMD_SECT 16'h0030
`define BSFC_CMD_BYP 16'h0020
`define BSFC_CMD_BYP_X1 16'h0090
`define BSFC_CMD_BYP_X2 16'h0000
`define BSFC_CMD_SUSP 16'h00b0
`define BSFC_CMD_RESUME 16'h0030
`define BSFC_CMD_RESET 16'h00f0

`define BSFC_POLL_BIT 7
`define BSFC_TOGGLE_BIT 6

`endif

// File: src/bsfc_pkg.sv
// Purpose: Types for the boot sector flash host controller
// Assumes: Constants come from bsfc_params.svh
// Notes: None
package bsfc_pkg;
   typedef enum logic [3:0] {
      BSFC_OP_READ,
      BSFC_OP_PROG,
      BSFC_OP_SECT_ERASE,
      BSFC_OP_BYP_ENTER,
      BSFC_OP_BYP_EXIT,
      BSFC_OP_SUSPEND,
      BSFC_OP_RESUME,
      BSFC_OP_RESET_CMD,
      BSFC_OP_HARD_RESET,
      BSFC_OP_STANDBY
   } bsfc_op_e;

   typedef struct packed {
      bsfc_op_e op;
      logic [20:0] addr;
      logic [15:0] data;
   } bsfc_req_s;

   typedef struct packed {
      logic [20:0] addr;
      logic [15:0] data;
   } bsfc_cycle_s;
endpackage
